// >>> rtl/pcnt_pkg.sv
// constants, register map and field layout of the pulse counter
package pcnt_pkg;
    // =======================================================
    // widths and timing
    localparam int ACC_W = 32;
    localparam int ADJ_W = 8;
    localparam int FLT_W = 22;
    localparam int CLK_MHZ = 250;
    localparam int HF_FILT_NS = 2500;
    localparam int HF_FILT_CYC = (HF_FILT_NS * CLK_MHZ + 999) / 1000;
    localparam int LF_FILT_US = 12500;
    localparam int LF_FILT_CYC = LF_FILT_US * CLK_MHZ;
    localparam int OSC_HZ = 1000;
    localparam int OSC_HALF_CYC = CLK_MHZ * 1000000 / (2 * OSC_HZ);
    localparam int WDOG_US = 1000;
    localparam int WDOG_CYC = WDOG_US * CLK_MHZ;
    localparam int OUT_DLY_US = 1000;
    localparam int OUT_DLY_CYC = OUT_DLY_US * CLK_MHZ;
    // =======================================================
    // address fields
    localparam int ASEL_GBL = 8;
    localparam int ACNT_LSB = 6;
    localparam int AREG_LSB = 2;
    // per counter register indices
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_ACC = 4'h1;
    localparam logic [3:0] REG_ADJ = 4'h2;
    localparam logic [3:0] REG_PRE = 4'h3;
    localparam logic [3:0] REG_ON = 4'h4;
    localparam logic [3:0] REG_OFF = 4'h5;
    localparam logic [3:0] REG_LIM_HI = 4'h6;
    localparam logic [3:0] REG_LIM_LO = 4'h7;
    localparam logic [3:0] REG_FLAGS = 4'h8;
    localparam logic [3:0] REG_STB0 = 4'h9;
    // global register indices
    localparam logic [3:0] GREG_OSC = 4'h0;
    localparam logic [3:0] GREG_WDOG = 4'h1;
    // control, watchdog and flag fields
    localparam int CTRL_DOWN = 0;
    localparam int CTRL_SINGLE = 1;
    localparam int CTRL_LF = 2;
    localparam int CTRL_OSC = 3;
    localparam int CTRL_STBNEG = 4;
    localparam int WD_EN = 0;
    localparam int WD_CLR = 1;
    localparam int FLAG_PRE = 0;
    localparam int FLAG_STB = 1;
    // reset values and answers
    localparam logic [31:0] LIM_HI_RST = 32'h7FFFFFFF;
    localparam logic [31:0] LIM_LO_RST = 32'h80000000;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;
endpackage

// >>> rtl/pulse_counter.sv
// pulse counter channels with preload, strobe capture, presets and axi4-lite registers
// Function
// R01: continuous mode wraps to opposite limit
// R02: single-shot stops at limit
// R03: single-shot reverse count leaves limit
// R04: separate signed two's complement accumulators
// R05: host reads and overwrites accumulators
// R06: adjust adds signed 8-bit offset
// R07: selectable filters, high-frequency default
// R08: counts up to filter's maximum rate
// R09: output on between on/off presets
// R10: strobe edge captures accumulator
// R11: watchdog failure forces outputs off
// R12: internal oscillator counts first counter
// R13: filtered count edge steps accumulator
// R14: preload edge loads preload register
// R15: preload sets host-visible flag
// R16: strobe edge selectable, always high-frequency
// R17: simultaneous strobes capture independently
// R18: strobe capture sets host-visible flag
// R19: capture holds until next strobe
// R20: host clears strobe flag
// R21: strobe with preload captures preload value
// R22: output follows count within delay
// R23: accumulators are 32 bits wide
// R24: field inputs synchronised before filtering
//
// Register access over AXI4-Lite and the address map are this design's own decisions.
`timescale 1ns/1ps
module pulse_counter #(
    parameter int NCNT = 2,
    parameter int NSTB = 2,
    parameter int LF_CYC = pcnt_pkg::LF_FILT_CYC,
    parameter int OSC_HALF = pcnt_pkg::OSC_HALF_CYC,
    parameter int WD_CYC = pcnt_pkg::WDOG_CYC
) (
    // clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // field inputs
    input wire logic [NCNT-1:0] count_pin,
    input wire logic [NCNT-1:0] preload_pin,
    input wire logic [NCNT*NSTB-1:0] strobe_pin,
    // field outputs and failure status
    output logic [NCNT-1:0] preset_out,
    output logic wdog_fault,
    // axi4-lite write
    input wire logic [8:0] s_awaddr,
    input wire logic s_awvalid,
    output logic s_awready,
    input wire logic [31:0] s_wdata,
    input wire logic [3:0] s_wstrb,
    input wire logic s_wvalid,
    output logic s_wready,
    output logic [1:0] s_bresp,
    output logic s_bvalid,
    input wire logic s_bready,
    // axi4-lite read
    input wire logic [8:0] s_araddr,
    input wire logic s_arvalid,
    output logic s_arready,
    output logic [31:0] s_rdata,
    output logic [1:0] s_rresp,
    output logic s_rvalid,
    input wire logic s_rready
);
    localparam int NIN = NCNT * (2 + NSTB);
    localparam int PB = NCNT;
    localparam int SB = 2 * NCNT;

    // byte-lane merge of a write into an old value
    function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                          input logic [3:0] s);
        logic [31:0] r;
        r = o;
        for (int b = 0; b < 4; b++) begin
            if (s[b]) begin
                r[8*b+:8] = n[8*b+:8];
            end
        end
        return r;
    endfunction

    // =======================================================
    // input synchronisers and filters
    logic [NIN-1:0] pin_raw;
    logic [NIN-1:0] s1_reg;
    logic [NIN-1:0] s2_reg;
    logic [NIN-1:0] flt_reg;
    logic [NIN-1:0] fltd_reg;
    logic [NIN-1:0] rise;
    logic [NIN-1:0] fall;
    logic [31:0] ctrl_reg [NCNT];

    assign pin_raw = {strobe_pin, preload_pin, count_pin};

    // two flops before anything looks at a pin
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            s1_reg <= '0;
            s2_reg <= '0;
            fltd_reg <= '0;
        end else begin
            s1_reg <= pin_raw; // R24
            s2_reg <= s1_reg; // R24
            fltd_reg <= flt_reg;
        end
    end

    assign rise = flt_reg & ~fltd_reg;
    assign fall = ~flt_reg & fltd_reg;

    // level must stay changed for the filter time before it is passed on
    genvar k;
    generate
        for (k = 0; k < NIN; k++) begin : g_flt
            logic [pcnt_pkg::FLT_W-1:0] fcnt_reg;
            logic [pcnt_pkg::FLT_W-1:0] flim;
            // strobes never take the long filter
            if (k >= SB) begin : g_hf
                assign flim = pcnt_pkg::FLT_W'(pcnt_pkg::HF_FILT_CYC - 1); // R16
            end else begin : g_sel
                assign flim = ctrl_reg[k % NCNT][pcnt_pkg::CTRL_LF] ?
                    pcnt_pkg::FLT_W'(LF_CYC - 1) :
                    pcnt_pkg::FLT_W'(pcnt_pkg::HF_FILT_CYC - 1); // R07 R08
            end
            always_ff @(posedge mclk or negedge resetn) begin
                if (!resetn) begin
                    fcnt_reg <= '0;
                    flt_reg[k] <= 1'b0;
                end else if (s2_reg[k] == flt_reg[k]) begin
                    fcnt_reg <= '0;
                end else if (fcnt_reg >= flim) begin
                    fcnt_reg <= '0;
                    flt_reg[k] <= s2_reg[k];
                end else begin
                    fcnt_reg <= fcnt_reg + 1'b1;
                end
            end
        end
    endgenerate

    // =======================================================
    // reference oscillator
    logic [31:0] osc_half_reg;
    logic [31:0] osc_cnt_reg;
    logic osc_reg;
    logic osc_rise_reg;

    // square wave, half period set by software
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            osc_cnt_reg <= '0;
            osc_reg <= 1'b0;
            osc_rise_reg <= 1'b0;
        end else if (osc_cnt_reg + 32'h1 >= osc_half_reg) begin
            osc_cnt_reg <= '0;
            osc_reg <= ~osc_reg; // R12
            osc_rise_reg <= ~osc_reg;
        end else begin
            osc_cnt_reg <= osc_cnt_reg + 32'h1;
            osc_rise_reg <= 1'b0;
        end
    end

    // =======================================================
    // register bus
    logic aw_fire;
    logic ar_fire;
    logic [3:0] wreg;
    logic [1:0] wcnt;
    logic [3:0] rreg;
    logic [1:0] rcnt;
    logic wr_ok;
    logic rd_ok;
    logic [31:0] rd_val;
    logic [31:0] pre_reg [NCNT];
    logic [31:0] on_reg [NCNT];
    logic [31:0] off_reg [NCNT];
    logic [31:0] hi_reg [NCNT];
    logic [31:0] lo_reg [NCNT];
    logic [31:0] flag_reg [NCNT];
    logic signed [31:0] acc_reg [NCNT];
    logic [31:0] stb_reg [NCNT*NSTB];
    logic [NCNT-1:0] acc_wr;
    logic [NCNT-1:0] adj_wr;
    logic [NCNT-1:0] flg_wr;
    logic wd_en_reg;
    logic [31:0] wd_cnt_reg;
    logic wd_wr;

    assign aw_fire = s_awvalid && s_wvalid && s_awready && s_wready;
    assign ar_fire = s_arvalid && s_arready;
    assign wreg = s_awaddr[pcnt_pkg::AREG_LSB+:4];
    assign wcnt = s_awaddr[pcnt_pkg::ACNT_LSB+:2];
    assign rreg = s_araddr[pcnt_pkg::AREG_LSB+:4];
    assign rcnt = s_araddr[pcnt_pkg::ACNT_LSB+:2];
    assign wr_ok = s_awaddr[pcnt_pkg::ASEL_GBL] ? (wreg <= pcnt_pkg::GREG_WDOG) :
        (32'(wcnt) < NCNT && 32'(wreg) < 32'(pcnt_pkg::REG_STB0) + NSTB);
    assign rd_ok = s_araddr[pcnt_pkg::ASEL_GBL] ? (rreg <= pcnt_pkg::GREG_WDOG) :
        (32'(rcnt) < NCNT && 32'(rreg) < 32'(pcnt_pkg::REG_STB0) + NSTB);
    assign wd_wr = aw_fire && wr_ok && s_awaddr[pcnt_pkg::ASEL_GBL]
        && wreg == pcnt_pkg::GREG_WDOG;

    // per counter write strobes
    always_comb begin
        for (int c = 0; c < NCNT; c++) begin
            acc_wr[c] = aw_fire && wr_ok && !s_awaddr[pcnt_pkg::ASEL_GBL]
                && 32'(wcnt) == c && wreg == pcnt_pkg::REG_ACC;
            adj_wr[c] = aw_fire && wr_ok && !s_awaddr[pcnt_pkg::ASEL_GBL]
                && 32'(wcnt) == c && wreg == pcnt_pkg::REG_ADJ;
            flg_wr[c] = aw_fire && wr_ok && !s_awaddr[pcnt_pkg::ASEL_GBL]
                && 32'(wcnt) == c && wreg == pcnt_pkg::REG_FLAGS;
        end
    end

    // write channel handshake and response
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            s_awready <= 1'b0;
            s_wready <= 1'b0;
            s_bvalid <= 1'b0;
            s_bresp <= pcnt_pkg::RESP_OKAY;
        end else begin
            s_awready <= s_awvalid && s_wvalid && !s_awready && !s_bvalid;
            s_wready <= s_awvalid && s_wvalid && !s_awready && !s_bvalid;
            if (aw_fire) begin
                s_bvalid <= 1'b1;
                s_bresp <= wr_ok ? pcnt_pkg::RESP_OKAY : pcnt_pkg::RESP_DECERR;
            end else if (s_bready) begin
                s_bvalid <= 1'b0;
            end
        end
    end

    // configuration registers
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            for (int c = 0; c < NCNT; c++) begin
                ctrl_reg[c] <= '0;
                pre_reg[c] <= '0; // R14
                on_reg[c] <= '0;
                off_reg[c] <= '0;
                hi_reg[c] <= pcnt_pkg::LIM_HI_RST;
                lo_reg[c] <= pcnt_pkg::LIM_LO_RST;
            end
            osc_half_reg <= 32'(OSC_HALF);
            wd_en_reg <= 1'b0;
        end else if (aw_fire && wr_ok) begin
            if (s_awaddr[pcnt_pkg::ASEL_GBL]) begin
                if (wreg == pcnt_pkg::GREG_OSC) begin
                    osc_half_reg <= merge(osc_half_reg, s_wdata, s_wstrb); // R12
                end else if (s_wstrb[0]) begin
                    wd_en_reg <= s_wdata[pcnt_pkg::WD_EN];
                end
            end else begin
                for (int c = 0; c < NCNT; c++) begin
                    if (32'(wcnt) == c) begin
                        case (wreg)
                            pcnt_pkg::REG_CTRL: ctrl_reg[c] <= merge(ctrl_reg[c], s_wdata, s_wstrb);
                            pcnt_pkg::REG_PRE: pre_reg[c] <= merge(pre_reg[c], s_wdata, s_wstrb);
                            pcnt_pkg::REG_ON: on_reg[c] <= merge(on_reg[c], s_wdata, s_wstrb);
                            pcnt_pkg::REG_OFF: off_reg[c] <= merge(off_reg[c], s_wdata, s_wstrb);
                            pcnt_pkg::REG_LIM_HI: hi_reg[c] <= merge(hi_reg[c], s_wdata, s_wstrb);
                            pcnt_pkg::REG_LIM_LO: lo_reg[c] <= merge(lo_reg[c], s_wdata, s_wstrb);
                            default: ;
                        endcase
                    end
                end
            end
        end
    end

    // read mux
    always_comb begin
        rd_val = '0;
        if (s_araddr[pcnt_pkg::ASEL_GBL]) begin
            if (rreg == pcnt_pkg::GREG_OSC) begin
                rd_val = osc_half_reg;
            end else begin
                rd_val = {30'h0, wdog_fault, wd_en_reg};
            end
        end else begin
            for (int c = 0; c < NCNT; c++) begin
                if (32'(rcnt) == c) begin
                    case (rreg)
                        pcnt_pkg::REG_CTRL: rd_val = ctrl_reg[c];
                        pcnt_pkg::REG_ACC: rd_val = acc_reg[c]; // R05
                        pcnt_pkg::REG_PRE: rd_val = pre_reg[c];
                        pcnt_pkg::REG_ON: rd_val = on_reg[c];
                        pcnt_pkg::REG_OFF: rd_val = off_reg[c];
                        pcnt_pkg::REG_LIM_HI: rd_val = hi_reg[c];
                        pcnt_pkg::REG_LIM_LO: rd_val = lo_reg[c];
                        pcnt_pkg::REG_FLAGS: rd_val = flag_reg[c];
                        default: begin
                            for (int s = 0; s < NSTB; s++) begin
                                if (32'(rreg) == 32'(pcnt_pkg::REG_STB0) + s) begin
                                    rd_val = stb_reg[c*NSTB+s];
                                end
                            end
                        end
                    endcase
                end
            end
        end
    end

    // read channel
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            s_arready <= 1'b0;
            s_rvalid <= 1'b0;
            s_rdata <= '0;
            s_rresp <= pcnt_pkg::RESP_OKAY;
        end else begin
            s_arready <= s_arvalid && !s_arready && !s_rvalid;
            if (ar_fire) begin
                s_rvalid <= 1'b1;
                s_rdata <= rd_ok ? rd_val : 32'h0;
                s_rresp <= rd_ok ? pcnt_pkg::RESP_OKAY : pcnt_pkg::RESP_DECERR;
            end else if (s_rready) begin
                s_rvalid <= 1'b0;
            end
        end
    end

    // =======================================================
    // watchdog: software must write the watchdog register in time
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            wd_cnt_reg <= '0;
            wdog_fault <= 1'b0;
        end else begin
            if (wd_wr || !wd_en_reg) begin
                wd_cnt_reg <= '0;
            end else if (wd_cnt_reg < 32'(WD_CYC)) begin
                wd_cnt_reg <= wd_cnt_reg + 32'h1;
            end
            if (wd_en_reg && wd_cnt_reg >= 32'(WD_CYC)) begin
                wdog_fault <= 1'b1;
            end else if (wd_wr && s_wstrb[0] && s_wdata[pcnt_pkg::WD_CLR]) begin
                wdog_fault <= 1'b0;
            end
        end
    end

    // =======================================================
    // counter channels
    logic [NCNT-1:0] cnt_ev;
    logic [NCNT-1:0] pre_ev;
    logic [NCNT*NSTB-1:0] stb_ev;
    logic signed [31:0] acc_next [NCNT];

    genvar c;
    genvar s;
    generate
        for (c = 0; c < NCNT; c++) begin : g_cnt
            // oscillator may feed only the first counter
            if (c == 0) begin : g_osc
                assign cnt_ev[c] = ctrl_reg[c][pcnt_pkg::CTRL_OSC] ?
                    osc_rise_reg : rise[c]; // R12
            end else begin : g_pin
                assign cnt_ev[c] = rise[c]; // R13
            end
            assign pre_ev[c] = rise[PB+c]; // R14

            // priority: host write, preload, adjust, count
            always_comb begin
                acc_next[c] = acc_reg[c];
                if (cnt_ev[c]) begin
                    if (!ctrl_reg[c][pcnt_pkg::CTRL_DOWN]) begin
                        if (acc_reg[c] == $signed(hi_reg[c])) begin
                            acc_next[c] = ctrl_reg[c][pcnt_pkg::CTRL_SINGLE] ?
                                acc_reg[c] : $signed(lo_reg[c]); // R01 R02
                        end else begin
                            acc_next[c] = acc_reg[c] + 32'sh1; // R03 R13
                        end
                    end else begin
                        if (acc_reg[c] == $signed(lo_reg[c])) begin
                            acc_next[c] = ctrl_reg[c][pcnt_pkg::CTRL_SINGLE] ?
                                acc_reg[c] : $signed(hi_reg[c]); // R01 R02
                        end else begin
                            acc_next[c] = acc_reg[c] - 32'sh1; // R03 R13
                        end
                    end
                end
                if (adj_wr[c] && s_wstrb[0]) begin
                    acc_next[c] = acc_reg[c] + 32'(signed'(s_wdata[pcnt_pkg::ADJ_W-1:0])); // R06
                end
                if (pre_ev[c]) begin
                    acc_next[c] = pre_reg[c]; // R14
                end
                if (acc_wr[c]) begin
                    acc_next[c] = merge(acc_reg[c], s_wdata, s_wstrb); // R05
                end
            end

            // one signed accumulator per counter
            always_ff @(posedge mclk or negedge resetn) begin
                if (!resetn) begin
                    acc_reg[c] <= '0;
                end else begin
                    acc_reg[c] <= acc_next[c]; // R04 R23
                end
            end

            // strobe captures, each into its own register
            for (s = 0; s < NSTB; s++) begin : g_stb
                assign stb_ev[c*NSTB+s] = ctrl_reg[c][pcnt_pkg::CTRL_STBNEG+s] ?
                    fall[SB+c*NSTB+s] : rise[SB+c*NSTB+s]; // R16
                always_ff @(posedge mclk or negedge resetn) begin
                    if (!resetn) begin
                        stb_reg[c*NSTB+s] <= '0;
                    end else if (stb_ev[c*NSTB+s]) begin
                        stb_reg[c*NSTB+s] <= pre_ev[c] ? pre_reg[c] : acc_reg[c]; // R10 R17 R21
                    end
                end
            end

            // sticky flags, write one to clear, a new event wins
            always_ff @(posedge mclk or negedge resetn) begin
                if (!resetn) begin
                    flag_reg[c] <= '0;
                end else begin
                    flag_reg[c] <= (flag_reg[c] & ~(flg_wr[c] ? s_wdata : 32'h0))
                        | 32'({stb_ev[c*NSTB+:NSTB], pre_ev[c]}); // R15 R18 R20
                end
            end

            // preset output, forced off on watchdog failure
            always_ff @(posedge mclk or negedge resetn) begin
                if (!resetn) begin
                    preset_out[c] <= 1'b0;
                end else if (wdog_fault) begin
                    preset_out[c] <= 1'b0; // R11
                end else if ($signed(on_reg[c]) <= $signed(off_reg[c])) begin
                    preset_out[c] <= acc_reg[c] >= $signed(on_reg[c])
                        && acc_reg[c] < $signed(off_reg[c]); // R09 R22
                end else begin
                    preset_out[c] <= acc_reg[c] >= $signed(on_reg[c])
                        || acc_reg[c] < $signed(off_reg[c]); // R09
                end
            end
        end
    endgenerate

    // =======================================================
    // checks on counter zero and the watchdog
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);
    logic c0_quiet;
    assign c0_quiet = !acc_wr[0] && !pre_ev[0] && !adj_wr[0];

    wrap_cont_a: assert property (c0_quiet && cnt_ev[0] && !ctrl_reg[0][1] && !ctrl_reg[0][0]
        && acc_reg[0] == $signed(hi_reg[0]) |=> acc_reg[0] == $signed($past(lo_reg[0])))
        else $error("no wrap at upper limit"); // R01
    stop_single_a: assert property (c0_quiet && cnt_ev[0] && ctrl_reg[0][1] && !ctrl_reg[0][0]
        && acc_reg[0] == $signed(hi_reg[0]) |=> $stable(acc_reg[0]))
        else $error("single-shot passed limit"); // R02
    back_off_a: assert property (c0_quiet && cnt_ev[0] && ctrl_reg[0][1] && ctrl_reg[0][0]
        && acc_reg[0] == $signed(hi_reg[0]) |=> acc_reg[0] == $past(acc_reg[0]) - 1)
        else $error("no back-off from limit"); // R03
    host_write_a: assert property (acc_wr[0] && s_wstrb == 4'hF |=> acc_reg[0] == $past(s_wdata))
        else $error("host write lost"); // R05
    adj_add_a: assert property (adj_wr[0] && s_wstrb[0] && !acc_wr[0] && !pre_ev[0]
        |=> acc_reg[0] == $past(acc_reg[0]) + $signed($past(s_wdata[7:0])))
        else $error("adjust wrong"); // R06
    pre_load_a: assert property (pre_ev[0] && !acc_wr[0]
        |=> acc_reg[0] == $past(pre_reg[0]) && flag_reg[0][0])
        else $error("preload wrong"); // R14 R15
    stb_hold_a: assert property (!stb_ev[0] |=> $stable(stb_reg[0]))
        else $error("capture changed"); // R19
    pre_stb_a: assert property (pre_ev[0] && stb_ev[0] |=> stb_reg[0] == $past(pre_reg[0]))
        else $error("strobe missed preload"); // R21
    stb_flag_a: assert property (stb_ev[1] |=> flag_reg[0][2] && stb_reg[1] == $past(
        pre_ev[0] ? pre_reg[0] : acc_reg[0])) else $error("strobe flag"); // R17 R18
    wdog_off_a: assert property (wdog_fault |=> preset_out == '0)
        else $error("output on in fault"); // R11
    out_delay_a: assert property (!wdog_fault && $signed(on_reg[0]) <= $signed(off_reg[0])
        && acc_reg[0] == $signed(on_reg[0]) && $signed(on_reg[0]) < $signed(off_reg[0])
        ##1 !wdog_fault |-> preset_out[0])
        else $error("output late"); // R09 R22

    wrap_c: cover property (cnt_ev[0] && acc_reg[0] == $signed(hi_reg[0]));
    two_stb_c: cover property (stb_ev[0] && stb_ev[1]);
    pre_stb_c: cover property (pre_ev[0] && stb_ev[0]);
    fault_c: cover property ($rose(wdog_fault));
endmodule // pulse_counter

// >>> dv/field_src.sv
// field pulse source model driving the count, preload and strobe pins
`timescale 1ns/1ps
module field_src (
    // clock
    input wire logic mclk,
    // field pins
    output logic [1:0] count_pin,
    output logic [1:0] preload_pin,
    output logic [3:0] strobe_pin
);
    // pins rest low between pulses
    initial {count_pin, preload_pin, strobe_pin} = 8'h00;
    // one clean pulse on the chosen pins, wider than the fast filter
    task pulse(input logic [1:0] c, input logic [1:0] p, input logic [3:0] s);
        @(posedge mclk);
        {count_pin, preload_pin, strobe_pin} <= {c, p, s};
        repeat (700) @(posedge mclk);
        {count_pin, preload_pin, strobe_pin} <= 8'h00;
        repeat (700) @(posedge mclk);
    endtask
endmodule // field_src

// >>> dv/tb_pulse_counter_with_strobe_preload.sv
// testbench for the pulse counter over its register bus and field pins
`timescale 1ns/1ps
module tb_pulse_counter_with_strobe_preload;
    logic mclk, resetn, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready;
    logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid, wdog_fault;
    logic [8:0] s_awaddr, s_araddr;
    logic [31:0] s_wdata, s_rdata, rdat;
    logic [1:0] s_bresp, s_rresp, rrsp, count_pin, preload_pin, preset_out;
    logic [3:0] strobe_pin, s_wstrb;
    int mismatches = 0;
    int samples_checked = 0;
    // =======================================================
    field_src src (.mclk(mclk), .count_pin(count_pin), .preload_pin(preload_pin),
        .strobe_pin(strobe_pin));
    pulse_counter #(.NCNT(2), .NSTB(2), .LF_CYC(40), .OSC_HALF(8), .WD_CYC(64)) dut (
        .mclk(mclk), .resetn(resetn), .count_pin(count_pin), .preload_pin(preload_pin),
        .strobe_pin(strobe_pin), .preset_out(preset_out), .wdog_fault(wdog_fault),
        .s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready),
        .s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid), .s_wready(s_wready),
        .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready),
        .s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready),
        .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready));
    // clock source
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    // one edge of a bounded wait
    task tick(inout int n);
        @(posedge mclk);
        n++;
        if (n > 100) begin
            mismatches++;
            wrap_up();
        end
    endtask
    // register write
    task wr(input logic [8:0] a, input logic [31:0] d);
        int n;
        logic aw, w;
        @(posedge mclk);
        {s_awaddr, s_wdata, s_awvalid, s_wvalid, s_bready} <= {a, d, 3'b111};
        {n, aw, w} = {32'd0, 2'b11};
        while (aw || w) begin
            tick(n);
            aw = aw && !s_awready;
            w = w && !s_wready;
            {s_awvalid, s_wvalid} <= {aw, w};
        end
        while (!s_bvalid) tick(n);
        s_bready <= 1'b0;
    endtask
    // register read into rdat and rrsp
    task rd(input logic [8:0] a);
        int n;
        logic ar;
        @(posedge mclk);
        {s_araddr, s_arvalid, s_rready} <= {a, 2'b11};
        {n, ar} = {32'd0, 1'b1};
        while (ar) begin
            tick(n);
            ar = !s_arready;
            s_arvalid <= ar;
        end
        while (!s_rvalid) tick(n);
        {rdat, rrsp} = {s_rdata, s_rresp};
        s_rready <= 1'b0;
    endtask
    // compare seen against expected
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task rc(input logic [8:0] a, input string nm, input logic [31:0] exp);
        rd(a);
        chk(nm, rdat, exp);
    endtask
    // verdict and end of run
    task wrap_up();
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // main sequence
    initial begin
        {resetn, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = 6'h00;
        {s_awaddr, s_araddr, s_wdata} = 50'h0;
        s_wstrb = 4'hF;
        repeat (3) @(posedge mclk);
        resetn <= 1'b1;
        rc(9'h018, "lim_hi", 32'h7FFFFFFF);
        rc(9'h004, "acc", 32'h0);
        src.pulse(2'h1, 2'h0, 4'h0);
        rc(9'h004, "acc", 32'h1);
        wr(9'h004, 32'h7FFFFFFF);
        src.pulse(2'h1, 2'h0, 4'h0);
        rc(9'h004, "acc", 32'h80000000);
        wr(9'h000, 32'h2);
        wr(9'h004, 32'h7FFFFFFF);
        src.pulse(2'h1, 2'h0, 4'h0);
        rc(9'h004, "acc", 32'h7FFFFFFF);
        wr(9'h000, 32'h3);
        src.pulse(2'h1, 2'h0, 4'h0);
        rc(9'h004, "acc", 32'h7FFFFFFE);
        wr(9'h008, 32'hFE);
        rc(9'h004, "acc", 32'h7FFFFFFC);
        $display("test counting done");
        wr(9'h00C, 32'h1234);
        src.pulse(2'h0, 2'h1, 4'h3);
        rc(9'h004, "acc", 32'h1234);
        rc(9'h024, "stb0", 32'h1234);
        rc(9'h028, "stb1", 32'h1234);
        rc(9'h020, "flags", 32'h7);
        wr(9'h020, 32'h7);
        rc(9'h020, "flags", 32'h0);
        src.pulse(2'h1, 2'h0, 4'h0);
        src.pulse(2'h0, 2'h0, 4'h1);
        rc(9'h024, "stb0", 32'h1233);
        rc(9'h028, "stb1", 32'h1234);
        rd(9'h1FC);
        chk("rresp", {30'h0, rrsp}, 32'h3);
        // falling strobe sees the count after the step that its rising edge coincided with
        wr(9'h000, 32'h13);
        src.pulse(2'h1, 2'h0, 4'h1);
        rc(9'h024, "stb0_fall", 32'h1232);
        $display("test capture done");
        rc(9'h100, "osc_half", 32'h8);
        // lane-limited write of the on point, then the off point
        s_wstrb <= 4'h3;
        wr(9'h010, 32'hFFFF1232);
        s_wstrb <= 4'hF;
        wr(9'h014, 32'h2000);
        rc(9'h010, "on", 32'h1232);
        chk("preset", {31'h0, preset_out[0]}, 32'h1);
        // let the watchdog run out, then clear it
        wr(9'h104, 32'h1);
        repeat (80) @(posedge mclk);
        chk("fault", {31'h0, wdog_fault}, 32'h1);
        chk("preset_off", {30'h0, preset_out}, 32'h0);
        rc(9'h104, "wdog", 32'h3);
        wr(9'h104, 32'h2);
        chk("fault_set_wins", {31'h0, wdog_fault}, 32'h1);
        wr(9'h104, 32'h2);
        chk("fault_clr", {31'h0, wdog_fault}, 32'h0);
        $display("test outputs done");
        wrap_up();
    end
endmodule // tb_pulse_counter_with_strobe_preload
